// file: bench/csg_properties.sv
`timescale 1ns/100ps
`default_nettype none
module csg_properties
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic external_reset_low
);
	// ----------------
	// frame bit count
	// ----------------
	logic sclk_q;
	logic [6:0] rises_q;
	logic [6:0] rises_d;
	// idle select clears the count, so stray edges between frames never accumulate
	assign rises_d = cs_n ? 7'h00 : rises_q + {6'h00, sclk & ~sclk_q};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_q <= 1'b0;
			rises_q <= 7'h00;
		end
		else
		begin
			sclk_q <= sclk;
			rises_q <= rises_d;
		end
	end
	// ------------
	// link timing
	// ------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	a_select_gap: assert property ($rose(cs_n) |-> cs_n[*3])
		else $error("select gap too short");
	a_lead_time: assert property ($fell(cs_n) |-> !sclk[*6])
		else $error("first clock edge too soon after select");
	a_half_period: assert property ($rose(sclk) |-> sclk[*6])
		else $error("serial clock high phase too short");
	a_mosi_hold: assert property (sclk |-> $stable(mosi))
		else $error("host data moved while clock high");
	a_miso_hold: assert property (sclk |-> $stable(miso))
		else $error("device data moved while clock high");
	a_frame_bits: assert property ($rose(cs_n) |-> rises_q == 7'h20)
		else $error("frame without exactly 32 clock rises");
	a_frame_span: assert property ($fell(cs_n) |-> ##[400:700] $rose(cs_n))
		else $error("frame length out of range");
	a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:4] miso_oe)
		else $error("device output not enabled in frame");
	a_oe_off_idle: assert property (cs_n[*5] |-> !miso_oe)
		else $error("device output enabled while idle");
	c_frame_done: cover property ($rose(cs_n));
	c_answer_out: cover property (miso_oe && !cs_n);
	c_reset_release: cover property ($rose(external_reset_low));
endmodule : csg_properties
`default_nettype wire

// file: bench/test_channel_safety_gate_and_diag.sv
`timescale 1ns/100ps
`default_nettype none
module test_channel_safety_gate_and_diag
	import csg_pkg::*;
;
	// short deadlines keep the run small; frames still fit well inside them
	localparam int WD_N = 3000;
	localparam int WD_I = 6000;
	localparam logic [31:0] STAT_W = {CMD_STATUS, 28'h0000000};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, oc_det, blank, short_to_ground, ol, off_ok, drive_on, act_off, sense;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] gcs;
	int errors, comparisons;
	csg_if lnk_if();
	csg_host csg_host_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .lnk(lnk_if));
	csg_device #(.WD_NORMAL_CYC(WD_N), .WD_INIT_CYC(WD_I)) csg_device_i(.pclk, .presetn,
		.lnk(lnk_if), .overcurrent_detect(oc_det), .oc_blank_running(blank),
		.short_to_ground_or_battery(short_to_ground), .open_load_detect(ol), .off_state_ok(off_ok),
		.gate_drive_on(drive_on), .gate_active_off(act_off), .gate_current_setting(gcs),
		.sensing_strategy_select(sense));
	csg_properties csg_properties_i(.pclk, .presetn, .sclk(lnk_if.sclk), .cs_n(lnk_if.cs_n),
		.mosi(lnk_if.mosi), .miso(lnk_if.miso), .miso_oe(lnk_if.miso_oe),
		.external_reset_low(lnk_if.external_reset_low));
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// --------------
	// bench helpers
	// --------------
	task automatic final_report;
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic timeout;
		errors++;
		final_report();
	endtask : timeout
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
			if (n > 16)
				timeout();
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next request never lands in the same time step
		@(posedge pclk);
	endtask : apb
	task automatic frame(input logic [31:0] w);
		int n;
		apb(1'b1, HOST_CMD_OFS, w);
		n = 0;
		do
		begin
			apb(1'b0, HOST_STAT_OFS, 32'h0);
			n++;
			if (n > 400)
				timeout();
		end
		while (rd[0] !== 1'b0);
		apb(1'b0, HOST_RX_OFS, 32'h0);
	endtask : frame
	// answer of a frame only arrives during the following one
	task automatic pair(input logic [31:0] w, input logic [31:0] exp);
		frame(w);
		frame(w);
		check(rd, exp);
	endtask : pair
	task automatic gates(input logic [7:0] on, input logic [7:0] off);
		repeat (6) @(posedge pclk);
		check(32'(drive_on), 32'(on));
		check(32'(act_off), 32'(off));
	endtask : gates
	// ---------
	// sequence
	// ---------
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		{oc_det, blank, short_to_ground, ol, off_ok} = 40'h0;
		errors = 0;
		comparisons = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		gates(8'h00, 8'hFF);
		apb(1'b0, 8'h20, 32'h0);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		apb(1'b1, HOST_CTRL_OFS, 32'hD);
		gates(8'h00, 8'h00);
		repeat (WD_N + 300) @(posedge pclk);
		frame(STAT_W);
		frame(STAT_W);
		// permit-loss bit masked: permit pin starts low while the device is still in reset
		check(rd & ~32'h1, {CMD_STATUS, 24'h0, 4'hA});
		pair(DIAG_REQUEST_FRAME, {DIAG_ANS_TAG, 24'hFFFFFF});
		apb(1'b1, HOST_CTRL_OFS, 32'hF);
		apb(1'b1, HOST_CTRL_OFS, 32'hD);
		repeat (WD_N + 300) @(posedge pclk);
		pair(STAT_W, {CMD_STATUS, 24'h0, 4'hC});
		apb(1'b1, HOST_PINS_OFS, 32'hFF);
		frame({CMD_CFG_B, 28'h200A500});
		gates(8'h00, 8'h00);
		check(32'(sense), 32'hA5);
		frame({CMD_CFG_A, 28'h00000FF});
		gates(8'hFF, 8'h00);
		apb(1'b1, HOST_CTRL_OFS, 32'h5);
		gates(8'hDF, 8'h20);
		apb(1'b1, HOST_CTRL_OFS, 32'hD);
		gates(8'hFF, 8'h00);
		pair(STAT_W, {CMD_STATUS, 24'h0, 4'h9});
		frame({CMD_KILL, 28'h00000FF});
		gates(8'h00, 8'hFF);
		frame({CMD_KILL, 28'h0000000});
		gates(8'hFF, 8'h00);
		repeat (WD_N + 300) @(posedge pclk);
		gates(8'hC0, 8'h3F);
		frame(STAT_W);
		gates(8'hFF, 8'h00);
		frame({CMD_CFG_B, 28'h300A500});
		repeat (WD_N + 300) @(posedge pclk);
		gates(8'h00, 8'hFF);
		frame(STAT_W);
		gates(8'hFF, 8'h00);
		frame({CMD_CFG_B, 28'h600A500});
		repeat (WD_N + 300) @(posedge pclk);
		gates(8'hFF, 8'h00);
		pair(STAT_W, {CMD_STATUS, 28'h0000000});
		frame({CMD_CFG_B, 28'h200A500});
		frame(DIAG_REQUEST_FRAME);
		oc_det <= 8'h01;
		@(posedge pclk);
		oc_det <= 8'h00;
		gates(8'hFE, 8'h01);
		check(32'(gcs[1:0]), 32'(GC_5MA));
		pair(DIAG_REQUEST_FRAME, {DIAG_ANS_TAG, {7{CODE_NO_OC}}, CODE_OC});
		check(32'(gcs[1:0]), 32'(GC_1MA));
		check(32'(drive_on), 32'hFE);
		apb(1'b1, HOST_PINS_OFS, 32'hFE);
		apb(1'b1, HOST_PINS_OFS, 32'hFF);
		gates(8'hFF, 8'h00);
		// peak-and-hold on channel one, full boost, readout needed before re-engage
		frame({CMD_CFG_B, 28'hA01A501});
		frame(DIAG_REQUEST_FRAME);
		blank <= 8'h01;
		oc_det <= 8'h01;
		@(posedge pclk);
		{blank, oc_det} <= 16'h0;
		gates(8'hFE, 8'h01);
		check(32'(gcs[1:0]), 32'(GC_20MA));
		apb(1'b1, HOST_PINS_OFS, 32'hFE);
		apb(1'b1, HOST_PINS_OFS, 32'hFF);
		gates(8'hFE, 8'h01);
		pair(DIAG_REQUEST_FRAME, {DIAG_ANS_TAG, {7{CODE_NO_OC}}, CODE_OC_PIN});
		apb(1'b1, HOST_PINS_OFS, 32'hFE);
		apb(1'b1, HOST_PINS_OFS, 32'hFF);
		gates(8'hFF, 8'h00);
		// off-state results latched at the readout, one-time turn-on code after
		apb(1'b1, HOST_PINS_OFS, 32'hF0);
		{short_to_ground, ol, off_ok} <= 24'h040C01;
		frame(DIAG_REQUEST_FRAME);
		{short_to_ground, ol, off_ok} <= 24'h0;
		apb(1'b1, HOST_PINS_OFS, 32'hFF);
		pair(DIAG_REQUEST_FRAME, {DIAG_ANS_TAG, {4{CODE_NO_OC}}, CODE_OL, CODE_STG_STB,
			CODE_NO_OC, CODE_NO_FAIL});
		frame({CMD_CFG_B, 28'h000A500});
		pair(DIAG_REQUEST_FRAME, {DIAG_ANS_TAG, 24'hFFFFFF});
		frame({CMD_CFG_A, 28'h0050F7F});
		frame({CMD_GATE, 28'h0000009});
		gates(8'h75, 8'h00);
		check(32'(gcs), 32'h9);
		apb(1'b1, HOST_CTRL_OFS, 32'hC);
		gates(8'h00, 8'hFF);
		apb(1'b1, HOST_CTRL_OFS, 32'hD);
		gates(8'h00, 8'h00);
		check(32'(gcs), 32'h0);
		pair(STAT_W, {CMD_STATUS, 24'h0, 4'hA});
		final_report();
	end
endmodule : test_channel_safety_gate_and_diag
`default_nettype wire

// file: pkg/csg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface csg_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic [7:0] channel_control_pin;
	logic channel_six_permit;
	logic shutoff_input_active_high;
	logic shutoff_input_active_low;
	logic external_reset_low;
	modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe,
		input channel_control_pin, input channel_six_permit,
		input shutoff_input_active_high, input shutoff_input_active_low,
		input external_reset_low);
	modport host (output sclk, output cs_n, output mosi, input miso, input miso_oe,
		output channel_control_pin, output channel_six_permit,
		output shutoff_input_active_high, output shutoff_input_active_low,
		output external_reset_low);
endinterface : csg_if
`default_nettype wire

// file: pkg/csg_pkg.sv
package csg_pkg;
	localparam int NCH = 8;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [31:0] DIAG_REQUEST_FRAME = 32'h9AAA0001;
	localparam logic [7:0] DIAG_ANS_TAG = 8'hD1;
	// frame command nibble in bits 31:28
	localparam logic [3:0] CMD_CFG_A = 4'h1;
	localparam logic [3:0] CMD_CFG_B = 4'h2;
	localparam logic [3:0] CMD_KILL = 4'h3;
	localparam logic [3:0] CMD_GATE = 4'h4;
	localparam logic [3:0] CMD_STATUS = 4'h5;
	// config word B field positions
	localparam int CFGB_STRAT = 0;
	localparam int CFGB_SENSE = 8;
	localparam int CFGB_PEAK = 16;
	localparam int CFGB_HBRIDGE = 24;
	localparam int CFGB_DIAG_EN = 25;
	localparam int CFGB_WD_OFF = 26;
	localparam int CFGB_BOOST = 27;
	localparam logic [23:0] CFG_A_RESET = 24'h000000;
	localparam logic [27:0] CFG_B_RESET = 28'h2000000;
	localparam logic [7:0] KILL_RESET = 8'h00;
	localparam logic [15:0] GATE_RESET = 16'h0000;
	localparam logic [7:0] WD_KILL_PLAIN = 8'h3F;
	localparam logic [7:0] BRIDGE_CHANS = 8'hC0;
	localparam logic [7:0] PERMIT_CHAN = 8'h20;
	localparam logic [1:0] GC_1MA = 2'h0;
	localparam logic [1:0] GC_5MA = 2'h1;
	localparam logic [1:0] GC_20MA = 2'h2;
	// timing
	localparam int PCLK_KHZ = 250000;
	localparam int COMM_TIMEOUT_NORMAL_MIN_MS = 55;
	localparam int COMM_TIMEOUT_NORMAL_MAX_MS = 85;
	localparam int COMM_TIMEOUT_INITIAL_MIN_MS = 110;
	localparam int COMM_TIMEOUT_INITIAL_MAX_MS = 165;
	localparam int COMM_TIMEOUT_NORMAL_CYC =
		(COMM_TIMEOUT_NORMAL_MIN_MS + COMM_TIMEOUT_NORMAL_MAX_MS) / 2 * PCLK_KHZ;
	localparam int COMM_TIMEOUT_INITIAL_CYC =
		(COMM_TIMEOUT_INITIAL_MIN_MS + COMM_TIMEOUT_INITIAL_MAX_MS) / 2 * PCLK_KHZ;
	localparam int SCLK_HALF_CYC = 8;
	// host register map
	localparam logic [7:0] HOST_CMD_OFS = 8'h00;
	localparam logic [7:0] HOST_RX_OFS = 8'h04;
	localparam logic [7:0] HOST_STAT_OFS = 8'h08;
	localparam logic [7:0] HOST_CTRL_OFS = 8'h0C;
	localparam logic [7:0] HOST_PINS_OFS = 8'h10;
	localparam int CTRL_RESET_REL = 0;
	localparam int CTRL_SHUT_HI = 1;
	localparam int CTRL_SHUT_LO = 2;
	localparam int CTRL_PERMIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h2;
	typedef enum logic [2:0] {
		CODE_OC_PIN = 3'h0,
		CODE_OC = 3'h1,
		CODE_STG_STB = 3'h2,
		CODE_OL = 3'h3,
		CODE_NO_FAIL = 3'h4,
		CODE_NO_OC = 3'h5,
		CODE_NO_OFF_FAIL = 3'h6,
		CODE_NONE = 3'h7
	} csg_code_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_LEAD = 2'b01,
		HS_SHIFT = 2'b11,
		HS_TRAIL = 2'b10
	} csg_hstate_t;
endpackage : csg_pkg

// file: rtl/csg_device.sv
// Chosen here: the serial frame decode and the pin synchronisers.
`timescale 1ns/100ps
`default_nettype none
module csg_device
	import csg_pkg::*;
#(
	parameter int WD_NORMAL_CYC = COMM_TIMEOUT_NORMAL_CYC,
	parameter int WD_INIT_CYC = COMM_TIMEOUT_INITIAL_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	csg_if.dev lnk,
	input wire logic [NCH-1:0] overcurrent_detect,
	input wire logic [NCH-1:0] oc_blank_running,
	input wire logic [NCH-1:0] short_to_ground_or_battery,
	input wire logic [NCH-1:0] open_load_detect,
	input wire logic [NCH-1:0] off_state_ok,
	output logic [NCH-1:0] gate_drive_on,
	output logic [NCH-1:0] gate_active_off,
	output logic [2*NCH-1:0] gate_current_setting,
	output logic [NCH-1:0] sensing_strategy_select
);
	localparam int SW = NCH + 7;
	localparam int WDW = $clog2(WD_INIT_CYC + 1);
	localparam logic [WDW-1:0] WD_NORMAL_LAST = WDW'(WD_NORMAL_CYC - 1);
	localparam logic [WDW-1:0] WD_INIT_LAST = WDW'(WD_INIT_CYC - 1);

	// ------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------
	logic [SW-1:0] sy1_q, sy2_q, sy3_q;
	wire [SW-1:0] pins_raw = {lnk.sclk, lnk.cs_n, lnk.mosi, lnk.channel_six_permit,
		lnk.shutoff_input_active_high, lnk.shutoff_input_active_low,
		lnk.external_reset_low, lnk.channel_control_pin};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sy1_q <= '0;
			sy2_q <= '0;
			sy3_q <= '0;
		end
		else
		begin
			sy1_q <= pins_raw;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	wire sclk_rise = sy2_q[NCH+6] & ~sy3_q[NCH+6];
	wire sclk_fall = ~sy2_q[NCH+6] & sy3_q[NCH+6];
	wire cs_s = sy2_q[NCH+5];
	wire cs_fall = ~cs_s & sy3_q[NCH+5];
	wire cs_rise = cs_s & ~sy3_q[NCH+5];
	wire mosi_s = sy2_q[NCH+4];
	wire permit_s = sy2_q[NCH+3];
	wire released = ~sy2_q[NCH+2] & sy2_q[NCH+1];
	wire xrst = ~sy2_q[NCH];
	wire xrst_rel = sy2_q[NCH] & ~sy3_q[NCH];
	wire [NCH-1:0] ctl_pin = sy2_q[NCH-1:0];

	// ------------------------------------------------
	// serial frame slave
	// ------------------------------------------------
	logic [31:0] rx_q, tx_q, answer_q;
	logic [5:0] bitcnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_q <= '0;
			tx_q <= '0;
			bitcnt_q <= '0;
		end
		else if (cs_fall)
		begin
			bitcnt_q <= '0;
			tx_q <= answer_q;
		end
		else if (!cs_s && sclk_rise)
		begin
			rx_q <= {rx_q[30:0], mosi_s};
			// saturate so an overlong frame never looks valid
			if (bitcnt_q != 6'h3F)
				bitcnt_q <= bitcnt_q + 6'h01;
		end
		else if (!cs_s && sclk_fall)
			tx_q <= {tx_q[30:0], 1'b0};
	end

	assign lnk.miso = tx_q[31];
	assign lnk.miso_oe = ~cs_s;

	wire frame_ok = cs_rise & (bitcnt_q == FRAME_BITS);
	wire [3:0] cmd = rx_q[31:28];
	wire diag_rd = frame_ok & (rx_q == DIAG_REQUEST_FRAME);
	wire wr_a = frame_ok & (cmd == CMD_CFG_A);
	wire wr_b = frame_ok & (cmd == CMD_CFG_B);
	wire wr_kill = frame_ok & (cmd == CMD_KILL);
	wire wr_gate = frame_ok & (cmd == CMD_GATE);
	wire st_rd = frame_ok & (cmd == CMD_STATUS);

	// ------------------------------------------------
	// configuration
	// ------------------------------------------------
	logic [23:0] cfg_a_q;
	logic [27:0] cfg_b_q;
	logic [7:0] kill_q;
	logic [15:0] gate_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_a_q <= CFG_A_RESET;
			cfg_b_q <= CFG_B_RESET;
			kill_q <= KILL_RESET;
			gate_q <= GATE_RESET;
		end
		else if (xrst)
		begin
			cfg_a_q <= CFG_A_RESET;
			cfg_b_q <= CFG_B_RESET;
			kill_q <= KILL_RESET;
			gate_q <= GATE_RESET;
		end
		else
		begin
			if (wr_a)
				cfg_a_q <= rx_q[23:0];
			if (wr_b)
				cfg_b_q <= rx_q[27:0];
			if (wr_kill)
				kill_q <= rx_q[7:0];
			if (wr_gate)
				gate_q <= rx_q[15:0];
		end
	end

	wire [NCH-1:0] en = cfg_a_q[7:0];
	wire [NCH-1:0] src_sel = cfg_a_q[15:8];
	wire [NCH-1:0] soft_on = cfg_a_q[23:16];
	wire [NCH-1:0] strat = cfg_b_q[CFGB_STRAT +: NCH];
	wire [NCH-1:0] peak = cfg_b_q[CFGB_PEAK +: NCH];
	wire hbridge = cfg_b_q[CFGB_HBRIDGE];
	wire diag_en = cfg_b_q[CFGB_DIAG_EN];
	wire wd_en = ~cfg_b_q[CFGB_WD_OFF];
	wire boost_all20 = cfg_b_q[CFGB_BOOST];
	assign sensing_strategy_select = cfg_b_q[CFGB_SENSE +: NCH];

	// ------------------------------------------------
	// communication watchdog
	// ------------------------------------------------
	logic wd_run_q, wd_init_q, wd_seen_q, wd_fail_q;
	logic [WDW-1:0] wd_cnt_q;
	wire [WDW-1:0] wd_last = wd_init_q ? WD_INIT_LAST : WD_NORMAL_LAST;
	wire wd_hold = xrst | ~released | ~wd_en;
	wire wd_expire = ~wd_hold & wd_run_q & ~frame_ok & (wd_cnt_q == wd_last);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wd_run_q <= 1'b0;
			wd_init_q <= 1'b0;
			wd_seen_q <= 1'b0;
			wd_fail_q <= 1'b0;
			wd_cnt_q <= '0;
		end
		else if (wd_hold)
		begin
			wd_run_q <= 1'b0;
			wd_init_q <= 1'b0;
			wd_fail_q <= 1'b0;
			wd_cnt_q <= '0;
			if (xrst)
				wd_seen_q <= 1'b0;
		end
		else if (!wd_run_q)
		begin
			wd_run_q <= 1'b1;
			wd_cnt_q <= '0;
			// already released when reset lets go: allow boot time
			wd_init_q <= xrst_rel & ~wd_seen_q;
		end
		else if (frame_ok)
		begin
			wd_cnt_q <= '0;
			wd_init_q <= 1'b0;
			wd_seen_q <= 1'b1;
			wd_fail_q <= 1'b0;
		end
		else if (wd_expire)
		begin
			wd_fail_q <= 1'b1;
			wd_init_q <= 1'b0;
			wd_cnt_q <= '0;
		end
		else
			wd_cnt_q <= wd_cnt_q + 1'b1;
	end

	// ------------------------------------------------
	// sticky flags and answer word
	// ------------------------------------------------
	logic permit_loss_q, xrst_flag_q, wd_flag_q;
	logic [3*NCH-1:0] code_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			permit_loss_q <= 1'b0;
			xrst_flag_q <= 1'b0;
			wd_flag_q <= 1'b0;
			answer_q <= '0;
		end
		else
		begin
			permit_loss_q <= ~permit_s | (permit_loss_q & ~st_rd);
			xrst_flag_q <= xrst | (xrst_flag_q & ~st_rd);
			wd_flag_q <= wd_expire | (wd_flag_q & ~st_rd);
			if (diag_rd)
				answer_q <= {DIAG_ANS_TAG, code_q};
			else if (st_rd)
				answer_q <= {CMD_STATUS, 24'h000000, wd_en, wd_flag_q, xrst_flag_q,
					permit_loss_q};
		end
	end

	// ------------------------------------------------
	// channel gating and overcurrent
	// ------------------------------------------------
	logic [NCH-1:0] ctl_q, trip_q, rdseen_q, boost_q, on_prev_q, offok_q;
	logic [NCH-1:0] gate_on_q, gate_off_q;
	logic [2*NCH-1:0] gate_cur_d, gate_cur_q;
	logic [3*NCH-1:0] code_d;
	logic [2:0] ev;

	wire [NCH-1:0] ctl = (src_sel & soft_on) | (~src_sel & ctl_pin);
	wire [NCH-1:0] ctl_edge = ctl ^ ctl_q;
	wire [NCH-1:0] permit_kill = permit_s ? '0 : PERMIT_CHAN;
	wire [NCH-1:0] wd_kill = wd_fail_q ? (WD_KILL_PLAIN | (hbridge ? BRIDGE_CHANS : '0))
		: '0;
	wire [NCH-1:0] oc_set = overcurrent_detect & gate_on_q & ~{NCH{xrst}};
	wire [NCH-1:0] need_rd = strat | (hbridge ? BRIDGE_CHANS : '0);
	wire [NCH-1:0] reengage = trip_q & ctl_edge & (~need_rd | rdseen_q);
	wire [NCH-1:0] trip_d = oc_set | (trip_q & ~reengage);
	wire [NCH-1:0] off_act = kill_q | permit_kill | wd_kill | trip_q;
	wire [NCH-1:0] turn_on = gate_on_q & ~on_prev_q;

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			gate_cur_d[2*i +: 2] = gate_q[2*i +: 2];
			// stronger pull from an overcurrent trip until the next diagnostic readout
			if (boost_q[i] && gate_q[2*i +: 2] == GC_1MA)
				gate_cur_d[2*i +: 2] = boost_all20 ? GC_20MA : GC_5MA;
			else if (boost_q[i] && gate_q[2*i +: 2] == GC_5MA)
				gate_cur_d[2*i +: 2] = GC_20MA;
		end
	end

	always_comb
	begin
		ev = CODE_NONE;
		code_d = code_q;
		for (int i = 0; i < NCH; i++)
		begin
			if (oc_set[i])
				ev = (peak[i] && oc_blank_running[i]) ? CODE_OC_PIN : CODE_OC;
			else if (!gate_on_q[i] && short_to_ground_or_battery[i])
				ev = CODE_STG_STB;
			else if (!gate_on_q[i] && open_load_detect[i])
				ev = CODE_OL;
			else if (turn_on[i] && offok_q[i])
				ev = CODE_NO_FAIL;
			else if (gate_on_q[i])
				ev = CODE_NO_OC;
			else if (off_state_ok[i])
				ev = CODE_NO_OFF_FAIL;
			else
				ev = CODE_NONE;
			// readout clears, yet a same-cycle event still lands
			code_d[3*i +: 3] = diag_rd ? CODE_NONE : code_q[3*i +: 3];
			if (ev < code_d[3*i +: 3])
				code_d[3*i +: 3] = ev;
			if (!diag_en)
				code_d[3*i +: 3] = CODE_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_q <= '0;
			trip_q <= '0;
			rdseen_q <= '0;
			boost_q <= '0;
			on_prev_q <= '0;
			offok_q <= '0;
			gate_on_q <= '0;
			gate_off_q <= '0;
			gate_cur_q <= GATE_RESET;
			code_q <= {NCH{CODE_NONE}};
		end
		else if (xrst)
		begin
			ctl_q <= '0;
			trip_q <= '0;
			rdseen_q <= '0;
			boost_q <= '0;
			on_prev_q <= '0;
			offok_q <= '0;
			gate_on_q <= '0;
			gate_off_q <= '1;
			gate_cur_q <= GATE_RESET;
			code_q <= {NCH{CODE_NONE}};
		end
		else
		begin
			ctl_q <= ctl;
			trip_q <= trip_d;
			rdseen_q <= (rdseen_q | {NCH{diag_rd}}) & trip_q & trip_d;
			boost_q <= oc_set | (boost_q & ~{NCH{diag_rd}});
			on_prev_q <= gate_on_q;
			offok_q <= (offok_q & ~turn_on) | (~gate_on_q & off_state_ok &
				~short_to_ground_or_battery & ~open_load_detect);
			gate_on_q <= en & ~off_act & ~oc_set & ctl;
			gate_off_q <= en & (off_act | oc_set);
			gate_cur_q <= gate_cur_d;
			code_q <= code_d;
		end
	end

	assign gate_drive_on = gate_on_q;
	assign gate_active_off = gate_off_q;
	assign gate_current_setting = gate_cur_q;
endmodule : csg_device
`default_nettype wire

// file: rtl/csg_host.sv
`timescale 1ns/100ps
`default_nettype none
module csg_host
	import csg_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	csg_if.host lnk
);
	localparam int DW = $clog2(HALF_CYC + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(HALF_CYC - 1);

	// ------------------------------------------------
	// register slave
	// ------------------------------------------------
	csg_hstate_t state_q;
	logic [31:0] cmd_q, rx_q, shreg_q, rxsh_q, rdata_q;
	logic [3:0] ctrl_q;
	logic [7:0] pins_q;
	wire busy = (state_q != HS_IDLE);
	wire sel_cmd = (paddr == HOST_CMD_OFS);
	wire sel_rx = (paddr == HOST_RX_OFS);
	wire sel_stat = (paddr == HOST_STAT_OFS);
	wire sel_ctrl = (paddr == HOST_CTRL_OFS);
	wire sel_pins = (paddr == HOST_PINS_OFS);
	wire hit = sel_cmd | sel_rx | sel_stat | sel_ctrl | sel_pins;
	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite & hit;
	// a command written while a frame runs is dropped
	wire start = wr & sel_cmd & ~busy;
	wire [31:0] rd_mux = sel_cmd ? cmd_q : sel_rx ? rx_q : sel_stat ? {31'h0, busy} :
		sel_ctrl ? {28'h0, ctrl_q} : sel_pins ? {24'h0, pins_q} : 32'h0;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = rdata_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q <= '0;
			ctrl_q <= CTRL_RESET;
			pins_q <= '0;
			cmd_q <= '0;
		end
		else
		begin
			if (setup)
				rdata_q <= rd_mux;
			if (wr && sel_ctrl)
				ctrl_q <= pwdata[3:0];
			if (wr && sel_pins)
				pins_q <= pwdata[7:0];
			if (start)
				cmd_q <= pwdata;
		end
	end

	assign lnk.external_reset_low = ctrl_q[CTRL_RESET_REL];
	assign lnk.shutoff_input_active_high = ctrl_q[CTRL_SHUT_HI];
	assign lnk.shutoff_input_active_low = ctrl_q[CTRL_SHUT_LO];
	assign lnk.channel_six_permit = ctrl_q[CTRL_PERMIT];
	assign lnk.channel_control_pin = pins_q;

	// ------------------------------------------------
	// frame master
	// ------------------------------------------------
	logic [1:0] miso_s_q;
	logic [DW-1:0] div_q;
	logic [5:0] nbit_q;
	logic sclk_q, cs_n_q, mosi_q;
	wire tick = (div_q == DIV_LAST);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			miso_s_q <= '0;
		else
			miso_s_q <= {miso_s_q[0], lnk.miso};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= HS_IDLE;
			div_q <= '0;
			nbit_q <= '0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			mosi_q <= 1'b0;
			shreg_q <= '0;
			rxsh_q <= '0;
			rx_q <= '0;
		end
		else
		begin
			div_q <= (busy && !tick) ? div_q + 1'b1 : '0;
			case (state_q)
				HS_IDLE:
					if (start)
					begin
						shreg_q <= pwdata;
						mosi_q <= pwdata[31];
						cs_n_q <= 1'b0;
						nbit_q <= '0;
						state_q <= HS_LEAD;
					end
				HS_LEAD:
					if (tick)
						state_q <= HS_SHIFT;
				HS_SHIFT:
					if (tick && !sclk_q)
					begin
						sclk_q <= 1'b1;
						rxsh_q <= {rxsh_q[30:0], miso_s_q[1]};
						nbit_q <= nbit_q + 6'h01;
					end
					else if (tick)
					begin
						sclk_q <= 1'b0;
						shreg_q <= {shreg_q[30:0], 1'b0};
						mosi_q <= shreg_q[30];
						if (nbit_q == FRAME_BITS)
						begin
							cs_n_q <= 1'b1;
							state_q <= HS_TRAIL;
						end
					end
				HS_TRAIL:
					if (tick)
					begin
						rx_q <= rxsh_q;
						state_q <= HS_IDLE;
					end
				default:
					state_q <= HS_IDLE;
			endcase
		end
	end

	assign lnk.sclk = sclk_q;
	assign lnk.cs_n = cs_n_q;
	assign lnk.mosi = mosi_q;
endmodule : csg_host
`default_nettype wire
